//--- rtl/dbsc_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dbsc_regs.svh"

// Contract
// - debug permit low blocks debug entry; debug state is left only on debug exit
// - halt request level enters debug after instruction
// - combined halt is request OR control bit1
// - mux select steers external scan cells
// - extest strobe: chain3, extest, capture-dr, phase2
// - intest strobe captures external chain outputs
// - exported clock: memory clock, debug clock
// - external conditions qualify breakpoint matches
// - float flag high while float_outputs_flag instruction held
// - debug ack high throughout debug state
// - instruction mirror updates on update-ir fall
module dbsc_top
#(
  parameter logic [3:0] EXTEST_CODE = 4'h0,
  parameter logic [3:0] INTEST_CODE = 4'hc,
  parameter logic [3:0] FLOAT_OUTPUTS_FLAG_CODE  = 4'h7
)
(
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire logic                      debug_permit_in,
  input  wire logic                      halt_request_in,
  input  wire logic [31:0]               dbg_ctrl_in,
  input  wire logic                      instr_done_in,
  input  wire logic                      debug_exit_in,
  input  wire logic [`DBSC_BP_W-1:0]     bp_match_in,
  input  wire logic [`DBSC_BP_W-1:0]     bp_cond_use_in,
  input  wire logic                      ext_condition_0_in,
  input  wire logic                      ext_condition_1_in,
  input  wire logic                      mclk_in,
  input  wire logic                      wait_stretch_n_in,
  input  wire logic                      debug_clock_in,
  input  wire logic                      test_clock_phase2_in,
  input  wire logic                      tck_fall_in,
  input  wire dbsc_pkg::dbsc_tap_t       tap_state_in,
  input  wire logic [`DBSC_IR_W-1:0]     tap_ir_in,
  input  wire logic [`DBSC_CHAIN_W-1:0]  scan_chain_in,
  output logic                           halt_request_combined_out,
  output logic                           debug_ack_out,
  output logic                           exported_clock_out,
  output logic                           ext_scan_mux_select_out,
  output logic                           ext_capture_strobe_out,
  output logic                           int_capture_strobe_out,
  output logic                           testchip_capture_clock_out,
  output logic                           float_outputs_flag_out,
  output logic [`DBSC_IR_W-1:0]          tap_instruction_mirror_out
);

  dbsc_pkg::dbsc_top_st_t st_r;
  dbsc_pkg::dbsc_top_st_t st_nxt;
  logic                   halt_comb;
  logic [`DBSC_BP_W-1:0]  ext_cond;
  logic [`DBSC_BP_W-1:0]  bp_qual;
  logic                   bp_hit;
  logic                   enter_req;
  logic                   ir_load;

  dbsc_scan_if sif ();

  // ---------------------------------------------------------------
  // request qualification
  // ---------------------------------------------------------------
  assign halt_comb = halt_request_in |
                     dbg_ctrl_in[`DBSC_CTRL_HALT_BIT];
  assign ext_cond  = {ext_condition_1_in, ext_condition_0_in};

  genvar gi;
  generate
    for (gi = 0; gi < `DBSC_BP_W; gi++)
    begin : g_bp
      assign bp_qual[gi] = bp_match_in[gi] &
                           (~bp_cond_use_in[gi] | ext_cond[gi]);
    end
  endgenerate

  assign bp_hit    = debug_permit_in & (|bp_qual);
  assign enter_req = debug_permit_in & (halt_comb | bp_hit);
  assign ir_load   = tck_fall_in &&
                     (tap_state_in == dbsc_pkg::DBSC_TAP_UPDATE_IR);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.halt_comb = halt_comb;
    case (st_r.dbg)
      dbsc_pkg::DBSC_RUN:
      begin
        if (enter_req && instr_done_in)
          st_nxt.dbg = dbsc_pkg::DBSC_DEBUG;
      end
      dbsc_pkg::DBSC_DEBUG:
      begin
        if (debug_exit_in)
          st_nxt.dbg = dbsc_pkg::DBSC_RUN;
      end
      default:
        st_nxt.dbg = dbsc_pkg::DBSC_RUN;
    endcase
    if (st_nxt.dbg == dbsc_pkg::DBSC_DEBUG)
      st_nxt.exported_clock = debug_clock_in;
    else
      st_nxt.exported_clock = mclk_in & wait_stretch_n_in;
    if (ir_load)
      st_nxt.mirror = tap_ir_in;
    st_nxt.float_flag = (st_nxt.mirror == FLOAT_OUTPUTS_FLAG_CODE);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st_r            <= '0;
      st_r.mirror     <= `DBSC_IR_RST;
      st_r.float_flag <= (`DBSC_IR_RST == FLOAT_OUTPUTS_FLAG_CODE);
    end
    else
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // scan strobes
  // ---------------------------------------------------------------
  assign sif.phase2      = test_clock_phase2_in;
  assign sif.tap_state   = tap_state_in;
  assign sif.instr       = st_r.mirror;
  assign sif.chain       = scan_chain_in;
  assign sif.extest_code = EXTEST_CODE;
  assign sif.intest_code = INTEST_CODE;

  dbsc_scan u_scan
  (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .sif      (sif.scan)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign halt_request_combined_out  = st_r.halt_comb;
  assign debug_ack_out              = (st_r.dbg == dbsc_pkg::DBSC_DEBUG);
  assign exported_clock_out         = st_r.exported_clock;
  assign ext_scan_mux_select_out    = sif.mux_sel;
  assign ext_capture_strobe_out     = sif.ext_cap;
  assign int_capture_strobe_out     = sif.int_cap;
  assign testchip_capture_clock_out = sif.ext_cap;
  assign float_outputs_flag_out     = st_r.float_flag;
  assign tap_instruction_mirror_out = st_r.mirror;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_running_at_boundary;
    !debug_ack_out && instr_done_in;
  endsequence

  sequence s_in_debug_held;
    debug_ack_out && !debug_exit_in;
  endsequence

  property p_halt_or;
    ##1 halt_request_combined_out ==
        ($past(halt_request_in) | $past(dbg_ctrl_in[1]));
  endproperty
  a_halt_or: assert property (p_halt_or)
    else $error("combined halt is not the or of its sources");

  property p_enter;
    s_running_at_boundary ##0 (debug_permit_in && halt_comb)
      |=> debug_ack_out;
  endproperty
  a_enter: assert property (p_enter)
    else $error("halt request did not enter debug state");

  property p_wait_boundary;
    !debug_ack_out && !instr_done_in |=> !debug_ack_out;
  endproperty
  a_wait_boundary: assert property (p_wait_boundary)
    else $error("debug entered mid instruction");

  property p_no_permit;
    !debug_permit_in && !debug_ack_out |=> !debug_ack_out;
  endproperty
  a_no_permit: assert property (p_no_permit)
    else $error("debug entered without permit");

  property p_ack_holds;
    s_in_debug_held |=> debug_ack_out;
  endproperty
  a_ack_holds: assert property (p_ack_holds)
    else $error("debug ack dropped inside debug state");

  property p_bp_enter;
    s_running_at_boundary ##0 (debug_permit_in && !halt_comb &&
      bp_match_in[0] && bp_cond_use_in[0] && ext_condition_0_in)
      |=> debug_ack_out;
  endproperty
  a_bp_enter: assert property (p_bp_enter)
    else $error("qualified breakpoint did not enter debug");

  property p_exported_clock_debug;
    $past(rst_n_in) && debug_ack_out |->
      exported_clock_out == $past(debug_clock_in);
  endproperty
  a_exported_clock_debug: assert property (p_exported_clock_debug)
    else $error("exported clock not the debug clock");

  property p_exported_clock_norm;
    $past(rst_n_in) && !debug_ack_out |-> exported_clock_out ==
      ($past(mclk_in) & $past(wait_stretch_n_in));
  endproperty
  a_exported_clock_norm: assert property (p_exported_clock_norm)
    else $error("exported clock not the memory clock");

  property p_mirror_stable;
    !ir_load |=> $stable(tap_instruction_mirror_out);
  endproperty
  a_mirror_stable: assert property (p_mirror_stable)
    else $error("instruction mirror changed outside update-ir");

  property p_mirror_load;
    ir_load |=> tap_instruction_mirror_out == $past(tap_ir_in);
  endproperty
  a_mirror_load: assert property (p_mirror_load)
    else $error("instruction mirror not loaded");

  property p_float;
    float_outputs_flag_out == (tap_instruction_mirror_out == FLOAT_OUTPUTS_FLAG_CODE);
  endproperty
  a_float: assert property (p_float)
    else $error("float flag disagrees with instruction");

endmodule // dbsc_top

`default_nettype wire

//--- rtl/dbsc_regs.svh
`ifndef DBSC_REGS_SVH
`define DBSC_REGS_SVH

// ---------------------------------------------------------------
// field positions and widths
// ---------------------------------------------------------------
`define DBSC_CTRL_HALT_BIT  1
`define DBSC_IR_W           4
`define DBSC_CHAIN_W        4
`define DBSC_BP_W           2

// ---------------------------------------------------------------
// reset values and fixed codes
// ---------------------------------------------------------------
`define DBSC_IR_RST         4'hf
`define DBSC_SCAN_CHAIN_BS  4'h3

`endif

//--- rtl/dbsc_pkg.sv
package dbsc_pkg;

  // ---------------------------------------------------------------
  // tap controller states as seen by this block
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    DBSC_TAP_RESET      = 4'h0,
    DBSC_TAP_IDLE       = 4'h1,
    DBSC_TAP_SELECT_DR  = 4'h2,
    DBSC_TAP_CAPTURE_DR = 4'h3,
    DBSC_TAP_SHIFT_DR   = 4'h4,
    DBSC_TAP_EXIT1_DR   = 4'h5,
    DBSC_TAP_PAUSE_DR   = 4'h6,
    DBSC_TAP_EXIT2_DR   = 4'h7,
    DBSC_TAP_UPDATE_DR  = 4'h8,
    DBSC_TAP_SELECT_IR  = 4'h9,
    DBSC_TAP_CAPTURE_IR = 4'ha,
    DBSC_TAP_SHIFT_IR   = 4'hb,
    DBSC_TAP_EXIT1_IR   = 4'hc,
    DBSC_TAP_PAUSE_IR   = 4'hd,
    DBSC_TAP_EXIT2_IR   = 4'he,
    DBSC_TAP_UPDATE_IR  = 4'hf
  } dbsc_tap_t;

  // ---------------------------------------------------------------
  // core debug state
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    DBSC_RUN   = 1'b0,
    DBSC_DEBUG = 1'b1
  } dbsc_dbg_t;

  typedef struct packed {
    dbsc_dbg_t  dbg;
    logic [3:0] mirror;
    logic       float_flag;
    logic       halt_comb;
    logic       exported_clock;
  } dbsc_top_st_t;

  typedef struct packed {
    logic ext_cap;
    logic int_cap;
    logic mux_sel;
  } dbsc_scan_st_t;

endpackage

//--- rtl/dbsc_scan_if.sv
`timescale 1ns/1ns
`default_nettype none

interface dbsc_scan_if;
  logic                   phase2;
  dbsc_pkg::dbsc_tap_t    tap_state;
  logic [3:0]             instr;
  logic [3:0]             chain;
  logic [3:0]             extest_code;
  logic [3:0]             intest_code;
  logic                   ext_cap;
  logic                   int_cap;
  logic                   mux_sel;

  modport ctl  (output phase2, tap_state, instr, chain, extest_code,
                intest_code, input ext_cap, int_cap, mux_sel);
  modport scan (input phase2, tap_state, instr, chain, extest_code,
                intest_code, output ext_cap, int_cap, mux_sel);
endinterface

`default_nettype wire

//--- rtl/dbsc_scan.sv
`timescale 1ns/1ns
`default_nettype none
`include "dbsc_regs.svh"

module dbsc_scan
(
  input  wire logic   clk_in,
  input  wire logic   rst_n_in,
  dbsc_scan_if.scan   sif
);

  dbsc_pkg::dbsc_scan_st_t st_r;
  dbsc_pkg::dbsc_scan_st_t st_nxt;
  logic                    bs_sel;
  logic                    cap_dr;

  // ---------------------------------------------------------------
  // boundary-scan strobes
  // ---------------------------------------------------------------
  assign bs_sel = (sif.chain == `DBSC_SCAN_CHAIN_BS);
  assign cap_dr = (sif.tap_state == dbsc_pkg::DBSC_TAP_CAPTURE_DR);

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.ext_cap = bs_sel && cap_dr && sif.phase2 &&
                     (sif.instr == sif.extest_code);
    st_nxt.int_cap = bs_sel && cap_dr && sif.phase2 &&
                     (sif.instr == sif.intest_code);
    st_nxt.mux_sel = (sif.instr == sif.extest_code) ||
                     (sif.instr == sif.intest_code);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sif.ext_cap = st_r.ext_cap;
  assign sif.int_cap = st_r.int_cap;
  assign sif.mux_sel = st_r.mux_sel;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_extest_capture;
    bs_sel && cap_dr && sif.phase2 && (sif.instr == sif.extest_code);
  endsequence

  property p_ext_strobe;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_extest_capture |=> sif.ext_cap;
  endproperty
  a_ext_strobe: assert property (p_ext_strobe)
    else $error("extest capture strobe missing");

  property p_ext_strobe_only;
    @(posedge clk_in) disable iff (!rst_n_in)
    !cap_dr |=> !sif.ext_cap && !sif.int_cap;
  endproperty
  a_ext_strobe_only: assert property (p_ext_strobe_only)
    else $error("capture strobe outside capture-dr");

  property p_int_strobe;
    @(posedge clk_in) disable iff (!rst_n_in)
    (bs_sel && cap_dr && sif.phase2 && (sif.instr == sif.intest_code))
      |=> sif.int_cap;
  endproperty
  a_int_strobe: assert property (p_int_strobe)
    else $error("intest capture strobe missing");

endmodule // dbsc_scan

`default_nettype wire

//--- sim/dbsc_far_model.sv
`timescale 1ns/1ns
`default_nettype none

module dbsc_far_model
(
  input  wire logic                clk_in,
  output var  dbsc_pkg::dbsc_tap_t tap_state_out,
  output var  logic [3:0]          tap_ir_out,
  output var  logic [3:0]          scan_chain_out,
  output var  logic                test_clock_phase2_out,
  output var  logic                tck_fall_out,
  output var  logic                debug_clock_out,
  output var  logic                ext_condition_0_out,
  output var  logic                ext_condition_1_out
);
  // test-chip capture clock is left without a load here
  logic debug_clock_run_r = 1'b0;
  logic debug_clock_r     = 1'b0;

  assign debug_clock_out = debug_clock_r;

  // debug clock runs only while debugging
  always @(posedge clk_in)
  begin
    if (debug_clock_run_r)
      debug_clock_r <= ~debug_clock_r;
  end

  task automatic set_tap(input dbsc_pkg::dbsc_tap_t st,
                         input logic [3:0] ir, input logic [3:0] ch,
                         input logic ph2, input logic fall);
    tap_state_out = st;
    tap_ir_out = ir;
    scan_chain_out = ch;
    test_clock_phase2_out = ph2;
    tck_fall_out = fall;
  endtask

  task automatic set_cond(input logic c0, input logic c1);
    ext_condition_0_out = c0;
    ext_condition_1_out = c1;
  endtask

  task automatic run_debug_clock(input logic on);
    debug_clock_run_r = on;
  endtask
endmodule // dbsc_far_model

`default_nettype wire

//--- sim/debug_request_and_scan_control_bench.sv
`timescale 1ns/1ns
`default_nettype none

`define DBSC_CHK(got, want, sel) \
  n_tests++; \
  if ((got) !== (want)) \
  begin \
    n_errors++; \
    $display("unexpected at %0t: out %0d got %h want %h", \
             $time, sel, got, want); \
  end

module debug_request_and_scan_control_bench;
  typedef struct {
    int         due;
    int         sel;
    logic [3:0] val;
  } dbsc_note_t;

  localparam logic [3:0] EXT_C = 4'h0;
  localparam logic [3:0] INT_C = 4'hc;
  localparam logic [3:0] HIZ_C = 4'h7;

  logic                clk_in = 1'b0;
  logic                rst_n, permit, halt, done_i, exit_i, mclk, wait_n;
  logic [31:0]         ctrl;
  logic [1:0]          match, use_c;
  dbsc_pkg::dbsc_tap_t tap;
  logic [3:0]          ir, chain, mir, prev;
  logic                ph2, fall, debug_clock, c0, c1;
  logic                hc, ack, exported_clock, mux, es, isb, tcc, flt;
  logic [3:0]          codes [4];
  int                  n_errors = 0;
  int                  n_tests = 0;
  int                  cyc = 0;
  int                  seed = 67;
  int                  i;
  dbsc_note_t          q [$];
  dbsc_note_t          nt;

  dbsc_top #(.EXTEST_CODE(EXT_C), .INTEST_CODE(INT_C), .FLOAT_OUTPUTS_FLAG_CODE(HIZ_C))
  dut (.clk_in(clk_in), .rst_n_in(rst_n), .debug_permit_in(permit),
    .halt_request_in(halt), .dbg_ctrl_in(ctrl), .instr_done_in(done_i),
    .debug_exit_in(exit_i), .bp_match_in(match), .bp_cond_use_in(use_c),
    .ext_condition_0_in(c0), .ext_condition_1_in(c1), .mclk_in(mclk),
    .wait_stretch_n_in(wait_n), .debug_clock_in(debug_clock),
    .test_clock_phase2_in(ph2), .tck_fall_in(fall), .tap_state_in(tap),
    .tap_ir_in(ir), .scan_chain_in(chain),
    .halt_request_combined_out(hc), .debug_ack_out(ack),
    .exported_clock_out(exported_clock), .ext_scan_mux_select_out(mux),
    .ext_capture_strobe_out(es), .int_capture_strobe_out(isb),
    .testchip_capture_clock_out(tcc), .float_outputs_flag_out(flt),
    .tap_instruction_mirror_out(mir));

  dbsc_far_model far (.clk_in(clk_in), .tap_state_out(tap),
    .tap_ir_out(ir), .scan_chain_out(chain), .test_clock_phase2_out(ph2),
    .tck_fall_out(fall), .debug_clock_out(debug_clock),
    .ext_condition_0_out(c0), .ext_condition_1_out(c1));

  always #5 clk_in = ~clk_in;

  always @(posedge clk_in) cyc <= cyc + 1;

  function automatic logic [3:0] obs(input int s);
    case (s)
      0: obs = {3'h0, hc};
      1: obs = {3'h0, ack};
      2: obs = {3'h0, exported_clock};
      3: obs = {3'h0, mux};
      4: obs = {3'h0, es};
      5: obs = {3'h0, isb};
      6: obs = {3'h0, flt};
      7: obs = mir;
      default: obs = {3'h0, tcc};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // monitor: every due note, oldest first, against the outputs
  // ---------------------------------------------------------------
  always @(negedge clk_in)
  begin
    while (q.size() > 0 && q[0].due <= cyc)
    begin
      nt = q.pop_front();
      `DBSC_CHK(obs(nt.sel), nt.val, nt.sel)
    end
  end

  task automatic step;
    @(posedge clk_in);
    #1;
  endtask

  task automatic exp(input int sel, input logic [3:0] v, input int lat);
    q.push_back('{cyc + lat, sel, v});
  endtask

  task automatic load(input logic [3:0] c);
    far.set_tap(dbsc_pkg::DBSC_TAP_UPDATE_IR, c, 4'h0, 1'b0, 1'b0);
    exp(7, prev, 1);
    step;
    far.set_tap(dbsc_pkg::DBSC_TAP_UPDATE_IR, c, 4'h0, 1'b0, 1'b1);
    exp(7, c, 1);
    exp(6, {3'h0, c == HIZ_C}, 1);
    step;
    far.set_tap(dbsc_pkg::DBSC_TAP_IDLE, c, 4'h0, 1'b0, 1'b0);
    exp(3, {3'h0, c == EXT_C || c == INT_C}, 1);
    step;
    prev = c;
  endtask

  task automatic cap(input logic [3:0] ch, input logic p,
                     input logic e, input logic n);
    far.set_tap(dbsc_pkg::DBSC_TAP_CAPTURE_DR, prev, ch, p, 1'b0);
    exp(4, {3'h0, e}, 1);
    exp(8, {3'h0, e}, 1);
    exp(5, {3'h0, n}, 1);
    step;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #20000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    far.set_cond(1'b0, 1'b0);
    far.set_tap(dbsc_pkg::DBSC_TAP_RESET, 4'hf, 4'h0, 1'b0, 1'b0);
    rst_n = 1'b0;
    permit = 1'b0;
    halt = 1'b0;
    ctrl = 32'h0;
    done_i = 1'b0;
    exit_i = 1'b0;
    mclk = 1'b0;
    wait_n = 1'b1;
    match = 2'h0;
    use_c = 2'h0;
    prev = 4'hf;
    repeat (8) step;
    rst_n = 1'b1;
    exp(7, 4'hf, 0);
    exp(6, 4'h0, 0);
    exp(1, 4'h0, 0);
    step;
    $display("test reset finished");
    for (i = 0; i < 16; i++)
    begin
      permit = 1'($random(seed));
      halt = 1'($random(seed));
      ctrl = $random(seed);
      exp(0, {3'h0, halt | ctrl[1]}, 1);
      step;
    end
    $display("test combined finished");
    ctrl = 32'h0;
    halt = 1'b1;
    permit = 1'b0;
    done_i = 1'b1;
    repeat (3)
    begin
      exp(1, 4'h0, 1);
      step;
    end
    permit = 1'b1;
    done_i = 1'b0;
    repeat (3)
    begin
      exp(1, 4'h0, 1);
      step;
    end
    done_i = 1'b1;
    far.run_debug_clock(1'b1);
    exp(1, 4'h1, 1);
    step;
    halt = 1'b0;
    done_i = 1'b0;
    repeat (6)
    begin
      mclk = ~debug_clock;
      exp(1, 4'h1, 1);
      exp(2, {3'h0, debug_clock}, 1);
      step;
    end
    exit_i = 1'b1;
    exp(1, 4'h0, 1);
    step;
    exit_i = 1'b0;
    far.run_debug_clock(1'b0);
    repeat (6)
    begin
      mclk = 1'($random(seed));
      wait_n = 1'($random(seed));
      exp(2, {3'h0, mclk & wait_n}, 1);
      step;
    end
    $display("test debug entry finished");
    for (i = 0; i < 2; i++)
    begin
      use_c = 2'b11;
      match = 2'(1 << i);
      done_i = 1'b1;
      far.set_cond(1'b0, 1'b0);
      exp(1, 4'h0, 1);
      step;
      far.set_cond(i == 0, i == 1);
      exp(1, 4'h1, 1);
      step;
      match = 2'b00;
      exit_i = 1'b1;
      exp(1, 4'h0, 1);
      step;
      exit_i = 1'b0;
    end
    done_i = 1'b0;
    $display("test breakpoints finished");
    codes = '{EXT_C, INT_C, HIZ_C, 4'($random(seed))};
    for (i = 0; i < 4; i++)
    begin
      load(codes[i]);
      cap(4'h2, 1'b1, 1'b0, 1'b0);
      repeat (2) cap(4'h3, 1'b1, prev == EXT_C, prev == INT_C);
      cap(4'h3, 1'b0, 1'b0, 1'b0);
    end
    $display("test scan finished");
    repeat (2) step;
    report_and_stop();
  end
endmodule // debug_request_and_scan_control_bench

`default_nettype wire
